// *** design/cec_host.sv ***
/*
  Controller that sets up, starts and reads a chain of 16-bit event counters.
  Assumes the counters take settings on a setup call, restart from zero on a
  start call and answer a read call with count_read_valid and their counts.
*/
`timescale 1ns/100ps
module cec_host #(
  parameter int NUM_CTR = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [cec_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cec_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cec_pkg::DATA_W-1:0] reg_rdata,
  output logic [NUM_CTR-1:0] count_edge_select,
  output logic [cec_pkg::GATE_W*NUM_CTR-1:0] gating_select,
  output logic [NUM_CTR-1:0] output_style_select,
  output logic [NUM_CTR-1:0] output_invert_select,
  output logic [NUM_CTR-1:0] count_continue,
  output logic [cec_pkg::TB_W*NUM_CTR-1:0] count_timebase,
  output logic counter_setup_call,
  output logic count_start_call,
  output logic count_read_call,
  output logic gate_drive,
  input wire logic [cec_pkg::CTR_W*NUM_CTR-1:0] count_value,
  input wire logic [NUM_CTR-1:0] count_overflow,
  input wire logic count_read_valid
);
  import cec_pkg::*;

  cec_state_t state_q;
  cec_state_t state_d;
  logic [DATA_W-1:0] config_q;
  logic [DATA_W-1:0] gate_len_q;
  logic [JOIN_W-1:0] snap_q;
  logic ovf_q;
  logic ovf_valid_q;
  logic refused_q;
  logic [NUM_CTR-1:0] edge_q;
  logic [GATE_W*NUM_CTR-1:0] gating_q;
  logic [NUM_CTR-1:0] style_q;
  logic [NUM_CTR-1:0] invert_q;
  logic [NUM_CTR-1:0] cont_q;
  logic [TB_W*NUM_CTR-1:0] tb_q;
  logic setup_call_q;
  logic start_call_q;
  logic read_call_q;
  logic gate_q;
  logic [DATA_W-1:0] rdata_q;
  logic cmd_wr;
  logic want_setup;
  logic want_start;
  logic want_read;
  logic want_pulse;
  logic cfg_bad;
  logic cfg_ovf_ok;
  logic timer_active;
  logic [JOIN_W-1:0] join_value;
  logic join_overflow;
  logic [GATE_W-1:0] user_gating;

  assign user_gating = config_q[CFG_GATE_LSB +: GATE_W];
  assign cmd_wr = reg_wr && (reg_addr == OFF_COMMAND);
  assign want_setup = cmd_wr && reg_wdata[CMD_SETUP];
  assign want_start = cmd_wr && reg_wdata[CMD_START];
  assign want_read = cmd_wr && reg_wdata[CMD_READ];
  assign want_pulse = cmd_wr && reg_wdata[CMD_GATE_PULSE];

  // Edge gating refused with continuous counting or with a chain
  assign cfg_bad = cec_edge_gating(user_gating) &&
                   (config_q[CFG_CONT] || (NUM_CTR > 1));

  // Overflow is meaningful only for the top counter's stop-on-wrap setup
  assign cfg_ovf_ok = (NUM_CTR > 1) ||
                      ((config_q[CFG_STYLE] == STYLE_TOGGLE) &&
                       (config_q[CFG_INV] == POL_NORMAL) &&
                       !config_q[CFG_CONT]);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      CEC_IDLE: begin
        if (want_setup && !cfg_bad) begin
          state_d = CEC_SETUP;
        end else if (want_start) begin
          state_d = CEC_START;
        end else if (want_read) begin
          state_d = CEC_READ;
        end
      end
      CEC_SETUP: state_d = CEC_IDLE;
      CEC_START: state_d = CEC_IDLE;
      CEC_READ: begin
        if (count_read_valid) begin
          state_d = CEC_IDLE;
        end
      end
      default: state_d = CEC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= CEC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Software registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      config_q <= CONFIG_RST;
      gate_len_q <= GATE_LEN_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFF_CONFIG) begin
        config_q <= reg_wdata;
      end
      if (reg_addr == OFF_GATE_LEN) begin
        gate_len_q <= reg_wdata;
      end
    end
  end

  // Refused setup sticks until the next accepted setup
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      refused_q <= 1'b0;
    end else if (state_q == CEC_IDLE && want_setup) begin
      refused_q <= cfg_bad;
    end
  end

  // Per-counter settings of the chain
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      edge_q <= '0;
      gating_q <= '0;
      style_q <= '0;
      invert_q <= '0;
      cont_q <= '0;
      tb_q <= '0;
      ovf_valid_q <= 1'b0;
    end else if (state_d == CEC_SETUP && state_q == CEC_IDLE) begin
      ovf_valid_q <= cfg_ovf_ok;
      for (int i = 0; i < NUM_CTR; i++) begin
        if (NUM_CTR == 1) begin
          // Single counter takes the user settings as they are
          edge_q[i] <= config_q[CFG_EDGE];
          gating_q[i*GATE_W +: GATE_W] <= user_gating;
          style_q[i] <= config_q[CFG_STYLE];
          invert_q[i] <= config_q[CFG_INV];
          cont_q[i] <= config_q[CFG_CONT];
          tb_q[i*TB_W +: TB_W] <= config_q[CFG_TB_LSB +: TB_W];
        end else if (i == 0) begin
          // Lowest counter counts the incoming edges and runs on
          edge_q[i] <= config_q[CFG_EDGE];
          gating_q[i*GATE_W +: GATE_W] <= user_gating;
          style_q[i] <= STYLE_PULSE;
          invert_q[i] <= POL_NORMAL;
          cont_q[i] <= 1'b1;
          tb_q[i*TB_W +: TB_W] <= config_q[CFG_TB_LSB +: TB_W];
        end else if (i == NUM_CTR - 1) begin
          // Top counter detects overflow
          edge_q[i] <= EDGE_RISE;
          gating_q[i*GATE_W +: GATE_W] <= GATING_NONE;
          style_q[i] <= STYLE_TOGGLE;
          invert_q[i] <= POL_NORMAL;
          cont_q[i] <= 1'b0;
          tb_q[i*TB_W +: TB_W] <= TB_CHAIN;
        end else begin
          edge_q[i] <= EDGE_RISE;
          gating_q[i*GATE_W +: GATE_W] <= GATING_NONE;
          style_q[i] <= STYLE_PULSE;
          invert_q[i] <= POL_NORMAL;
          cont_q[i] <= 1'b1;
          tb_q[i*TB_W +: TB_W] <= TB_CHAIN;
        end
      end
    end
  end

  // One-cycle calls to the counters
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      setup_call_q <= 1'b0;
      start_call_q <= 1'b0;
      read_call_q <= 1'b0;
    end else begin
      setup_call_q <= (state_q == CEC_IDLE) && (state_d == CEC_SETUP);
      start_call_q <= (state_q == CEC_IDLE) && (state_d == CEC_START);
      read_call_q <= (state_q == CEC_IDLE) && (state_d == CEC_READ);
    end
  end

  cec_chain_join #(
    .NUM_CTR(NUM_CTR)
  ) u_join (
    .count_value(count_value),
    .count_overflow(count_overflow),
    .join_value(join_value),
    .join_overflow(join_overflow)
  );

  // Snapshot of count and overflow; a start clears both
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      snap_q <= '0;
      ovf_q <= 1'b0;
    end else if (state_q == CEC_IDLE && state_d == CEC_START) begin
      snap_q <= '0;
      ovf_q <= 1'b0;
    end else if (state_q == CEC_READ && count_read_valid) begin
      snap_q <= join_value;
      ovf_q <= join_overflow;
    end
  end

  cec_gate_timer u_gate (
    .core_clk(core_clk),
    .reset(reset),
    .start(want_pulse),
    .len(gate_len_q),
    .active_q(timer_active)
  );

  // Level gate held by software or a timed gate pulse
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= config_q[CFG_GATE_LVL] || timer_active;
    end
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFF_CONFIG: rdata_q <= config_q;
        OFF_GATE_LEN: rdata_q <= gate_len_q;
        OFF_STATUS: begin
          rdata_q <= '0;
          rdata_q[STS_OVF] <= ovf_q && ovf_valid_q;
          rdata_q[STS_OVF_VALID] <= ovf_valid_q;
          rdata_q[STS_BUSY] <= (state_q != CEC_IDLE);
          rdata_q[STS_REFUSED] <= refused_q;
          rdata_q[STS_GATE] <= gate_q;
        end
        OFF_COUNT_LO: rdata_q <= snap_q[31:0];
        OFF_COUNT_HI: rdata_q <= snap_q[63:32];
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign count_edge_select = edge_q;
  assign gating_select = gating_q;
  assign output_style_select = style_q;
  assign output_invert_select = invert_q;
  assign count_continue = cont_q;
  assign count_timebase = tb_q;
  assign counter_setup_call = setup_call_q;
  assign count_start_call = start_call_q;
  assign count_read_call = read_call_q;
  assign gate_drive = gate_q;

  a_no_edge_cont: assert property (@(posedge core_clk) disable iff (reset)
    counter_setup_call |-> !(count_continue[0] &&
      cec_edge_gating(gating_select[GATE_W-1:0])))
    else $error("edge gating set up with continuous counting");

  a_top_stops: assert property (@(posedge core_clk) disable iff (reset)
    counter_setup_call |-> !count_continue[NUM_CTR-1] ||
      (NUM_CTR == 1 && config_q[CFG_CONT]))
    else $error("top counter set to run past wrap");

  a_low_runs_on: assert property (@(posedge core_clk) disable iff (reset)
    (counter_setup_call && NUM_CTR > 1) |->
      count_continue[0] && output_style_select[0] == STYLE_PULSE)
    else $error("low chained counter does not run on with pulses");

  a_chain_timebase: assert property (@(posedge core_clk) disable iff (reset)
    (counter_setup_call && NUM_CTR > 1) |->
      count_timebase[TB_W*NUM_CTR-1 -: TB_W] == TB_CHAIN &&
      gating_select[GATE_W*NUM_CTR-1 -: GATE_W] == GATING_NONE)
    else $error("top counter not fed from the one below");

  a_setup_once: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == CEC_IDLE && want_setup && cfg_bad) |=>
      !counter_setup_call ##1 !counter_setup_call)
    else $error("refused setup still reached the counters");

  a_start_clears: assert property (@(posedge core_clk) disable iff (reset)
    count_start_call |-> snap_q == '0 && !ovf_q)
    else $error("start did not clear count and overflow");

  a_read_snapshot: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == CEC_READ && count_read_valid) |=>
      snap_q == $past(join_value) && ovf_q == $past(count_overflow[NUM_CTR-1]))
    else $error("read answer not captured");

  a_read_call: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == CEC_IDLE && want_read && !want_setup && !want_start) |=>
      count_read_call ##1 !count_read_call)
    else $error("read call not a single pulse");

  a_ovf_meaning: assert property (@(posedge core_clk) disable iff (reset)
    (reg_rd && reg_addr == OFF_STATUS && !ovf_valid_q) |=> !reg_rdata[STS_OVF])
    else $error("overflow reported under a meaningless setup");
endmodule // cec_host

// *** design/cec_pkg.sv ***
/*
  Shared constants of the event counter controller: register map, field
  positions, reset values, device setting codes and the controller states.
  Assumes a chain of at most four 16-bit counters behind the controller.
*/
package cec_pkg;
  localparam int CTR_W = 16;
  localparam int JOIN_W = 64;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int GATE_W = 3;
  localparam int TB_W = 4;

  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COMMAND = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_GATE_LEN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_COUNT_HI = 8'h14;

  localparam int CFG_EDGE = 0;
  localparam int CFG_GATE_LSB = 1;
  localparam int CFG_STYLE = 4;
  localparam int CFG_INV = 5;
  localparam int CFG_CONT = 6;
  localparam int CFG_TB_LSB = 8;
  localparam int CFG_GATE_LVL = 12;

  localparam int CMD_SETUP = 0;
  localparam int CMD_START = 1;
  localparam int CMD_READ = 2;
  localparam int CMD_GATE_PULSE = 3;

  localparam int STS_OVF = 0;
  localparam int STS_OVF_VALID = 1;
  localparam int STS_BUSY = 2;
  localparam int STS_REFUSED = 3;
  localparam int STS_GATE = 4;

  localparam logic [DATA_W-1:0] CONFIG_RST = 32'h0000_0600;
  localparam logic [DATA_W-1:0] GATE_LEN_RST = 32'h0000_0100;

  localparam logic [GATE_W-1:0] GATING_NONE = 3'h0;
  localparam logic [GATE_W-1:0] GATING_HIGH = 3'h1;
  localparam logic [GATE_W-1:0] GATING_LOW = 3'h2;
  localparam logic [GATE_W-1:0] GATING_RISE = 3'h3;
  localparam logic [GATE_W-1:0] GATING_FALL = 3'h4;

  localparam logic EDGE_RISE = 1'b0;
  localparam logic STYLE_TOGGLE = 1'b0;
  localparam logic STYLE_PULSE = 1'b1;
  localparam logic POL_NORMAL = 1'b0;
  localparam logic [TB_W-1:0] TB_CHAIN = 4'h0;
  localparam logic [TB_W-1:0] TB_SRC_FIRST = 4'h6;
  localparam logic [TB_W-1:0] TB_SRC_LAST = 4'ha;

  typedef enum logic [1:0] {
    CEC_IDLE = 2'b00,
    CEC_SETUP = 2'b01,
    CEC_START = 2'b10,
    CEC_READ = 2'b11
  } cec_state_t;

  function automatic logic cec_edge_gating(input logic [GATE_W-1:0] g);
    cec_edge_gating = (g == GATING_RISE) || (g == GATING_FALL);
  endfunction
endpackage

// *** design/cec_chain_join.sv ***
/*
  Joins the per-counter counts of a chain into one wide value and picks the
  overflow of the top counter. Assumes 1 to 4 counters, lowest first.
*/
`timescale 1ns/100ps
module cec_chain_join #(
  parameter int NUM_CTR = 2
) (
  input wire logic [cec_pkg::CTR_W*NUM_CTR-1:0] count_value,
  input wire logic [NUM_CTR-1:0] count_overflow,
  output logic [cec_pkg::JOIN_W-1:0] join_value,
  output logic join_overflow
);
  import cec_pkg::*;

  // Lowest counter in the low bits, each next one 16 bits higher
  always_comb begin
    join_value = '0;
    join_value[CTR_W*NUM_CTR-1:0] = count_value;
  end

  // Only the top counter's overflow means anything
  assign join_overflow = count_overflow[NUM_CTR-1];
endmodule // cec_chain_join

// *** design/cec_gate_timer.sv ***
/*
  Makes one gate pulse of a programmed number of clock cycles.
  Assumes len is held stable while the pulse runs; len of 0 acts as 1.
*/
`timescale 1ns/100ps
module cec_gate_timer (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [cec_pkg::DATA_W-1:0] len,
  output logic active_q
);
  import cec_pkg::*;

  logic [DATA_W-1:0] left_q;

  // Known fixed gate length for frequency measurement
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      left_q <= '0;
      active_q <= 1'b0;
    end else if (start && !active_q) begin
      left_q <= (len == '0) ? 32'h0000_0001 : len;
      active_q <= 1'b1;
    end else if (active_q) begin
      left_q <= left_q - 32'h0000_0001;
      active_q <= (left_q != 32'h0000_0001);
    end
  end
endmodule // cec_gate_timer

// *** tb/cec_dev_model.sv ***
/*
  Behavioural chain of 16-bit event counters facing the controller.
  Assumes one core clock; five source lines serve timebase codes 6 to 10.
*/
`timescale 1ns/100ps
module cec_dev_model #(
  parameter int N = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [N-1:0] count_edge_select,
  input wire logic [cec_pkg::GATE_W*N-1:0] gating_select,
  input wire logic [N-1:0] count_continue,
  input wire logic [cec_pkg::TB_W*N-1:0] count_timebase,
  input wire logic counter_setup_call,
  input wire logic count_start_call,
  input wire logic count_read_call,
  input wire logic gate_drive,
  input wire logic [4:0] src,
  input wire logic [cec_pkg::CTR_W*N-1:0] preset,
  input wire logic [3:0] read_lat,
  output logic [cec_pkg::CTR_W*N-1:0] count_value,
  output logic [N-1:0] count_overflow,
  output logic count_read_valid
);
  import cec_pkg::*;
  logic [N-1:0] edge_q, cont_q, run_q, ovf_q, tick, wrap;
  logic [GATE_W-1:0] gate_q;
  logic [TB_W-1:0] tb_q;
  logic [CTR_W*N-1:0] cnt_q;
  logic [4:0] s1_q, s2_q, s3_q;
  logic [2:0] sel;
  logic [3:0] wait_q;
  logic gd_q, arm_q, pend_q, hit, en;

  assign sel = 3'(tb_q - TB_SRC_FIRST);
  always_ff @(posedge core_clk) begin
    {gd_q, s3_q, s2_q, s1_q} <= {gate_drive, s2_q, s1_q, src};
  end

  // Settings saved on setup, used by later starts
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      edge_q <= '0;
      cont_q <= '0;
      gate_q <= '0;
      tb_q <= TB_SRC_FIRST;
    end else if (counter_setup_call) begin
      edge_q <= count_edge_select;
      cont_q <= count_continue;
      gate_q <= gating_select[GATE_W-1:0];
      tb_q <= count_timebase[TB_W-1:0];
    end
  end

  always_comb begin
    hit = 1'b0;
    if (tb_q >= TB_SRC_FIRST && tb_q <= TB_SRC_LAST) begin
      hit = edge_q[0] ? s3_q[sel] & ~s2_q[sel] : s2_q[sel] & ~s3_q[sel];
    end
    case (gate_q)
      GATING_NONE: en = 1'b1;
      GATING_HIGH: en = gate_drive;
      GATING_LOW: en = !gate_drive;
      default: en = arm_q;
    endcase
    tick = '0;
    tick[0] = hit && en;
    for (int i = 0; i < N; i++) begin
      wrap[i] = tick[i] && run_q[i] && cnt_q[i*CTR_W +: CTR_W] == 16'hffff;
      if (i + 1 < N) begin
        tick[i+1] = wrap[i];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      arm_q <= 1'b0;
    end else if (count_start_call) begin
      arm_q <= 1'b0;
    end else if ((gate_q == GATING_RISE && gate_drive && !gd_q) ||
                 (gate_q == GATING_FALL && !gate_drive && gd_q)) begin
      arm_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      ovf_q <= '0;
      run_q <= '0;
    end else if (count_start_call) begin
      cnt_q <= preset; // Zero unless a test preloads
      ovf_q <= '0;
      run_q <= '1;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (tick[i] && run_q[i]) begin
          cnt_q[i*CTR_W +: CTR_W] <= cnt_q[i*CTR_W +: CTR_W] + 16'h1;
        end
        if (wrap[i] && !cont_q[i]) begin
          run_q[i] <= 1'b0;
          ovf_q[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
      wait_q <= '0;
    end else if (count_read_call) begin
      pend_q <= read_lat != 4'h0;
      wait_q <= read_lat - 4'h1;
    end else if (pend_q) begin
      pend_q <= wait_q != 4'h0;
      wait_q <= wait_q - 4'h1;
    end
  end

  assign count_read_valid = count_read_call ? read_lat == 4'h0 : pend_q && wait_q == 4'h0;
  // Live counts, inverted outside the answer cycle
  assign count_value = count_read_valid ? cnt_q : ~cnt_q;
  assign count_overflow = count_read_valid ? ovf_q : ~ovf_q;
endmodule // cec_dev_model

// *** tb/cec_host_tb.sv ***
/*
  Self-checking bench of the counter controller with a two-counter chain.
  Assumes the behavioural counter chain in cec_dev_model.
*/
`timescale 1ns/100ps
module cec_host_tb;
  import cec_pkg::*;
  localparam int N = 2;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [N-1:0] edge_sel, style_sel, inv_sel, cont, covf;
  logic [GATE_W*N-1:0] gate_sel;
  logic [TB_W*N-1:0] tbase;
  logic setup_call, start_call, read_call, gate_drive, read_valid;
  logic [CTR_W*N-1:0] cval;
  logic [CTR_W*N-1:0] preset = '0;
  logic [4:0] src = '0;
  logic [3:0] read_lat = '0;
  logic [DATA_W-1:0] exp_q[$];
  logic rd_d = 1'b0;
  logic abort = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  int n_valid = 0;
  int n1, n2, g;

  always #2 core_clk = ~core_clk;

  cec_host #(.NUM_CTR(N)) dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_edge_select(edge_sel), .gating_select(gate_sel), .output_style_select(style_sel),
    .output_invert_select(inv_sel), .count_continue(cont), .count_timebase(tbase),
    .counter_setup_call(setup_call), .count_start_call(start_call),
    .count_read_call(read_call), .gate_drive(gate_drive), .count_value(cval),
    .count_overflow(covf), .count_read_valid(read_valid));

  cec_dev_model #(.N(N)) model (.core_clk(core_clk), .reset(reset),
    .count_edge_select(edge_sel), .gating_select(gate_sel), .count_continue(cont),
    .count_timebase(tbase), .counter_setup_call(setup_call), .count_start_call(start_call),
    .count_read_call(read_call), .gate_drive(gate_drive), .src(src), .preset(preset),
    .read_lat(read_lat), .count_value(cval), .count_overflow(covf),
    .count_read_valid(read_valid));

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH %0t read %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One bus cycle; a read notes its expected data
  task automatic bus(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic r);
    if (r) begin
      exp_q.push_back(d);
    end
    reg_addr <= a;
    reg_wdata <= r ? '0 : d;
    reg_wr <= !r;
    reg_rd <= r;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      src[k] <= 1'b1;
      repeat (3) @(posedge core_clk);
      src[k] <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask

  task automatic snap();
    int seen = n_valid;
    int i = 0;
    read_lat <= 4'($urandom_range(0, 5));
    @(posedge core_clk);
    bus(OFF_COMMAND, 32'h4, 1'b0);
    while (n_valid == seen && i < 40) begin
      @(posedge core_clk);
      i++;
    end
    if (n_valid == seen) begin
      abort = 1'b1;
    end
    repeat (2) @(posedge core_clk);
  endtask

  function automatic logic [DATA_W-1:0] cfg(input logic e, input logic [GATE_W-1:0] gt,
                                            input logic [TB_W-1:0] t);
    cfg = (DATA_W'(t) << CFG_TB_LSB) | (DATA_W'(gt) << CFG_GATE_LSB) | (DATA_W'(e) << CFG_EDGE);
  endfunction

  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      chk(reg_rdata, exp_q.pop_front());
    end
    if (read_valid === 1'b1) begin
      n_valid++;
    end
  end

  always @(posedge core_clk) begin
    if (abort) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h76925a2c));
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    bus(OFF_CONFIG, CONFIG_RST, 1'b1);
    bus(OFF_GATE_LEN, GATE_LEN_RST, 1'b1);
    bus(8'h18, 32'hffff_ffff, 1'b0);
    bus(8'h18, 32'h0, 1'b1);
    // Every source code, both edges, read twice while counting
    for (int k = 0; k < 5; k++) begin
      bus(OFF_CONFIG, cfg(k[0], GATING_NONE, TB_SRC_FIRST + 4'(k)), 1'b0);
      bus(OFF_COMMAND, 32'h1, 1'b0);
      bus(OFF_COMMAND, 32'h2, 1'b0);
      n1 = $urandom_range(1, 12);
      n2 = $urandom_range(1, 12);
      pulse(k, n1);
      pulse((k + 1) % 5, 2);
      snap();
      bus(OFF_COUNT_LO, 32'(n1), 1'b1);
      bus(OFF_STATUS, 32'h2, 1'b1);
      pulse(k, n2);
      snap();
      bus(OFF_COUNT_LO, 32'(n1 + n2), 1'b1);
      bus(OFF_COUNT_HI, 32'h0, 1'b1);
    end
    bus(OFF_CONFIG, cfg(1'b0, GATING_RISE, TB_SRC_FIRST), 1'b0);
    bus(OFF_COMMAND, 32'h1, 1'b0);
    bus(OFF_STATUS, 32'ha, 1'b1);
    bus(OFF_CONFIG, cfg(1'b0, GATING_NONE, TB_SRC_FIRST), 1'b0);
    bus(OFF_COMMAND, 32'h1, 1'b0);
    bus(OFF_STATUS, 32'h2, 1'b1);
    // Chain wrap: low counter runs on, top counter stops
    preset <= 32'hffff_fffe;
    bus(OFF_COMMAND, 32'h2, 1'b0);
    pulse(0, 3);
    snap();
    bus(OFF_COUNT_LO, 32'h1, 1'b1);
    bus(OFF_STATUS, 32'h3, 1'b1);
    preset <= '0;
    bus(OFF_COMMAND, 32'h2, 1'b0);
    bus(OFF_STATUS, 32'h2, 1'b1);
    snap();
    bus(OFF_COUNT_LO, 32'h0, 1'b1);
    // Level gate of programmed length
    g = $urandom_range(44, 60);
    bus(OFF_GATE_LEN, 32'(g), 1'b0);
    bus(OFF_GATE_LEN, 32'(g), 1'b1);
    bus(OFF_CONFIG, cfg(1'b0, GATING_HIGH, TB_SRC_FIRST), 1'b0);
    bus(OFF_COMMAND, 32'h1, 1'b0);
    bus(OFF_COMMAND, 32'h2, 1'b0);
    pulse(0, 2);
    bus(OFF_COMMAND, 32'h8, 1'b0);
    @(posedge core_clk);
    bus(OFF_STATUS, 32'h12, 1'b1);
    pulse(0, 5);
    repeat (g) @(posedge core_clk);
    pulse(0, 3);
    snap();
    bus(OFF_COUNT_LO, 32'h5, 1'b1);
    repeat (3) @(posedge core_clk);
    give_verdict();
  end
endmodule // cec_host_tb
